// [rtl/irq_vec_pkg.sv]
// constants and types shared by the interrupt vectoring logic
package irq_vec_pkg;
  localparam int NUM_SOURCES = 118;
  localparam int NUM_TRAPS = 8;
  localparam int NUM_VECTORS = 126;
  localparam int ADDR_W = 24;
  localparam int VEC_W = 7;
  localparam int PRIO_W = 3;
  localparam int LEVEL_W = 4;
  localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
  localparam logic [23:0] ALTERNATE_TABLE_BASE = 24'h000104;
  localparam logic [23:0] RESET_ADDR = 24'h000000;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_DISABLED = 3'h0;
  localparam logic [2:0] LEVEL_MASK_ALL = 3'h7;
  localparam int ALT_SELECT_BIT = 15;
  localparam int LEVEL_FIELD_LSB = 5;
  localparam int LEVEL_FIELD_MSB = 7;
  localparam int TRAP_LEVEL_BIT = 3;
  localparam int NIBBLE_W = 4;
  // trap vector numbers
  localparam logic [6:0] VEC_OSC_FAIL = 7'h01;
  localparam logic [6:0] VEC_ADDR_ERR = 7'h02;
  localparam logic [6:0] VEC_STACK_ERR = 7'h03;
  localparam logic [6:0] VEC_MATH_ERR = 7'h04;
  // fixed trap levels and the no-winner level
  localparam logic [3:0] LEVEL_MATH_ERR = 4'hB;
  localparam logic [3:0] LEVEL_STACK_ERR = 4'hC;
  localparam logic [3:0] LEVEL_ADDR_ERR = 4'hD;
  localparam logic [3:0] LEVEL_OSC_FAIL = 4'hE;
  localparam logic [3:0] LEVEL_NONE = 4'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } req_state_type;
endpackage

// [rtl/irq_winner_if.sv]
// winner information passed from the arbiter to the top
`timescale 1ns/1ps
interface irq_winner_if;
  logic valid;
  logic [6:0] vector;
  logic [3:0] level;
  logic is_trap;
  modport arb (output valid, output vector, output level, output is_trap);
  modport top (input valid, input vector, input level, input is_trap);
endinterface

// [rtl/irq_arbiter.sv]
// combinational arbiter: highest level wins, ties to lowest vector
`timescale 1ns/1ps
module irq_arbiter #(
  parameter int NUM_SRC = irq_vec_pkg::NUM_SOURCES
) (
  // pending inputs
  input wire logic [NUM_SRC-1:0] src_pending,
  input wire logic [NUM_SRC*3-1:0] src_prio,
  input wire logic [3:0] trap_pending,
  // result
  irq_winner_if.arb win
);
  logic [3:0] lvl [NUM_SRC+5];
  logic [6:0] vec [NUM_SRC+5];
  logic [3:0] trap_lvl [4];
  logic [6:0] trap_vec [4];

  assign trap_lvl[0] = irq_vec_pkg::LEVEL_OSC_FAIL;
  assign trap_lvl[1] = irq_vec_pkg::LEVEL_ADDR_ERR;
  assign trap_lvl[2] = irq_vec_pkg::LEVEL_STACK_ERR;
  assign trap_lvl[3] = irq_vec_pkg::LEVEL_MATH_ERR;
  assign trap_vec[0] = irq_vec_pkg::VEC_OSC_FAIL;
  assign trap_vec[1] = irq_vec_pkg::VEC_ADDR_ERR;
  assign trap_vec[2] = irq_vec_pkg::VEC_STACK_ERR;
  assign trap_vec[3] = irq_vec_pkg::VEC_MATH_ERR;

  assign lvl[0] = irq_vec_pkg::LEVEL_NONE;
  assign vec[0] = 7'h00;

  // traps first: unique fixed levels, so order among them is by level
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_trap
      always_comb begin
        if (trap_pending[t] && trap_lvl[t] > lvl[t]) begin // R20 R21
          lvl[t+1] = trap_lvl[t];
          vec[t+1] = trap_vec[t];
        end else begin
          lvl[t+1] = lvl[t];
          vec[t+1] = vec[t];
        end
      end
    end
  endgenerate

  // user sources: strict greater keeps the lower vector on a tie
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      always_comb begin
        if (src_pending[i] && src_prio[i*3 +: 3] != irq_vec_pkg::PRIO_DISABLED // R16
            && {1'b0, src_prio[i*3 +: 3]} > lvl[i+4]) begin // R18
          lvl[i+5] = {1'b0, src_prio[i*3 +: 3]}; // R09
          vec[i+5] = 7'(irq_vec_pkg::NUM_TRAPS + i);
        end else begin
          lvl[i+5] = lvl[i+4];
          vec[i+5] = vec[i+4];
        end
      end
    end
  endgenerate

  assign win.valid = lvl[NUM_SRC+4] != irq_vec_pkg::LEVEL_NONE; // R10
  assign win.level = lvl[NUM_SRC+4];
  assign win.vector = vec[NUM_SRC+4];
  assign win.is_trap = lvl[NUM_SRC+4][3];
endmodule

// [rtl/prioritized_interrupt_vectoring.sv]
// interrupt controller top: priority regs, cpu level, request to core
`timescale 1ns/1ps
// Overview of operation
// R01: all sources merge into one core request
// R02: primary table starts at 0x000004, step two
// R03: 126 vectors: 8 traps, 118 sources
// R04: each vector yields a 24-bit address
// R05: alternate select bit switches every vector fetch
// R06: trap vectors map to fixed table addresses
// R07: reset bypasses controller; execution starts at zero
// R08: take only when level exceeds cpu level
// R09: user levels 0-7, traps 8-15
// R10: user level zero is never taken
// R11: cpu level from status and control bits
// R12: software rewrites level field; 111 masks users
// R13: trap bit set by hardware, cleared only
// R14: level field read-only when nesting disabled
// R15: priority in low nibble bits, top reads zero
// R16: priorities 1 to 7, zero disables
// R17: all priorities reset to level 4
// R18: highest priority wins, ties to lowest vector
// R19: only strictly higher priority preempts service; during a trap the code compares to 8 plus the level field
// R20: math error 11, stack error 12 soft traps
// R21: address error 13, oscillator 14 hard traps
// R22: vector and level held until core acknowledges
// R23: arbitration registered once per clock
module prioritized_interrupt_vectoring #(
  parameter int NUM_SRC = irq_vec_pkg::NUM_SOURCES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // user sources and traps (core clock domain)
  input wire logic [NUM_SRC-1:0] src_pending,
  input wire logic [3:0] trap_pending,
  // priority register write port, one 16-bit register holds four nibbles
  input wire logic prio_wr,
  input wire logic [4:0] prio_wr_index,
  input wire logic [15:0] prio_wr_data,
  input wire logic [4:0] prio_rd_index,
  output logic [15:0] prio_rd_data,
  // status level field and trap bit access
  input wire logic status_wr,
  input wire logic [15:0] status_wr_data,
  input wire logic control_wr,
  input wire logic [15:0] control_wr_data,
  input wire logic nesting_disable,
  output logic [15:0] core_status_reg,
  output logic [15:0] core_control_reg,
  // irq_control_two
  input wire logic ctrl_two_wr,
  input wire logic [15:0] ctrl_two_wr_data,
  output logic [15:0] irq_control_two,
  // request to core
  output logic irq_request,
  output logic [6:0] irq_vector,
  output logic [3:0] irq_level,
  output logic [23:0] irq_vector_addr,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic [23:0] reset_addr
);
  localparam int NUM_REGS = (NUM_SRC + 3) / 4;

  if (NUM_SRC < 1 || NUM_SRC > irq_vec_pkg::NUM_SOURCES) begin : g_bad_num_src
    $error("NUM_SRC out of range");
  end

  //--------------------------------------------------------------
  // priority fields
  //--------------------------------------------------------------
  logic [NUM_SRC*3-1:0] prio_q;
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_prio
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          prio_q[i*3 +: 3] <= irq_vec_pkg::PRIO_RESET; // R17
        end else if (prio_wr && prio_wr_index == 5'(i / 4)) begin
          prio_q[i*3 +: 3] <= prio_wr_data[(i % 4)*4 +: 3]; // R15
        end
      end
    end
  endgenerate

  always_comb begin
    prio_rd_data = 16'h0000;
    for (int n = 0; n < 4; n++) begin
      if (int'(prio_rd_index) * 4 + n < NUM_SRC) begin
        prio_rd_data[n*4 +: 3] = prio_q[(int'(prio_rd_index) * 4 + n) * 3 +: 3]; // R15
      end
    end
  end

  //--------------------------------------------------------------
  // cpu level
  //--------------------------------------------------------------
  logic [2:0] level_field_q;
  logic trap_bit_q;
  logic alt_sel_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_field_q <= 3'h0;
    end else if (irq_request && irq_ack && !irq_level[3]) begin
      level_field_q <= irq_level[2:0];
    end else if (status_wr && !nesting_disable) begin // R14
      level_field_q <= status_wr_data[irq_vec_pkg::LEVEL_FIELD_MSB:irq_vec_pkg::LEVEL_FIELD_LSB]; // R12
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_bit_q <= 1'b0;
    end else if (irq_request && irq_ack && irq_level[3]) begin
      trap_bit_q <= 1'b1; // R13
    end else if (control_wr && !control_wr_data[irq_vec_pkg::TRAP_LEVEL_BIT]) begin
      trap_bit_q <= 1'b0; // R13
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alt_sel_q <= 1'b0;
    end else if (ctrl_two_wr) begin
      alt_sel_q <= ctrl_two_wr_data[irq_vec_pkg::ALT_SELECT_BIT]; // R05
    end
  end

  always_comb begin
    core_status_reg = 16'h0000;
    core_status_reg[irq_vec_pkg::LEVEL_FIELD_MSB:irq_vec_pkg::LEVEL_FIELD_LSB] = level_field_q;
    core_control_reg = 16'h0000;
    core_control_reg[irq_vec_pkg::TRAP_LEVEL_BIT] = trap_bit_q;
    irq_control_two = 16'h0000;
    irq_control_two[irq_vec_pkg::ALT_SELECT_BIT] = alt_sel_q;
  end

  //--------------------------------------------------------------
  // arbitration
  //--------------------------------------------------------------
  irq_winner_if win ();

  irq_arbiter #(.NUM_SRC(NUM_SRC)) u_arb (
    .src_pending(src_pending),
    .src_prio(prio_q),
    .trap_pending(trap_pending),
    .win(win)
  );

  // trap level bit forms the top of the effective level when in a trap
  logic [3:0] eff_level;
  assign eff_level = {trap_bit_q, level_field_q}; // R11

  logic take;
  assign take = win.valid && win.level > eff_level; // R08 R19

  //--------------------------------------------------------------
  // request toward the core
  //--------------------------------------------------------------
  irq_vec_pkg::req_state_type state_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= irq_vec_pkg::ST_IDLE;
      irq_vector <= 7'h00;
      irq_level <= 4'h0;
    end else begin
      unique case (state_q)
        irq_vec_pkg::ST_IDLE: begin
          if (take) begin // R23
            state_q <= irq_vec_pkg::ST_OFFER;
            irq_vector <= win.vector;
            irq_level <= win.level;
          end
        end
        irq_vec_pkg::ST_OFFER: begin
          if (irq_ack) begin // R22
            state_q <= irq_vec_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  assign irq_request = state_q == irq_vec_pkg::ST_OFFER; // R01

  // table base plus two per vector
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_vector_addr <= irq_vec_pkg::PRIMARY_TABLE_BASE;
    end else if (state_q == irq_vec_pkg::ST_IDLE && take) begin
      irq_vector_addr <= (alt_sel_q ? irq_vec_pkg::ALTERNATE_TABLE_BASE // R05 R06
                                    : irq_vec_pkg::PRIMARY_TABLE_BASE) + {16'h0000, win.vector, 1'b0}; // R02 R03 R04
    end
  end

  assign reset_addr = irq_vec_pkg::RESET_ADDR; // R07

  logic unused;
  assign unused = irq_return ^ win.is_trap;
endmodule

// [verification/irq_vec_sva.sv]
// assertions on the interrupt vectoring top ports
`timescale 1ns/1ps
module irq_vec_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // handshake and mode
  input wire logic irq_request,
  input wire logic irq_ack,
  input wire logic nesting_disable,
  // register views
  input wire logic [15:0] prio_rd_data,
  input wire logic [15:0] core_status_reg,
  input wire logic [15:0] core_control_reg,
  input wire logic [15:0] irq_control_two,
  // offer toward the core
  input wire logic [6:0] irq_vector,
  input wire logic [3:0] irq_level,
  input wire logic [23:0] irq_vector_addr,
  input wire logic [23:0] reset_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic taken = irq_request && irq_ack;
  a_offer_holds: assert property (irq_request && !irq_ack |=> irq_request && $stable({irq_vector, irq_level}))
    else $error("offer changed before ack");
  a_addr_from_vector: assert property (irq_request |-> irq_vector_addr ==
    (irq_control_two[15] ? 24'h000104 : 24'h000004) + {16'h0, irq_vector, 1'b0}) else $error("bad vector address");
  a_level_above_cpu: assert property ($rose(irq_request) |->
    irq_level > $past({core_control_reg[3], core_status_reg[7:5]})) else $error("offer not above cpu level");
  a_nibble_top_zero: assert property ((prio_rd_data & 16'h8888) == 16'h0)
    else $error("priority nibble top bit set");
  a_ack_ends_offer: assert property (taken |=> !irq_request)
    else $error("request held after ack");
  a_trap_sets_bit: assert property (taken && irq_level[3] |=> core_control_reg[3])
    else $error("trap bit not set");
  a_ack_loads_field: assert property (taken && !irq_level[3] |=> core_status_reg[7:5] == $past(irq_level[2:0]))
    else $error("level field not loaded");
  a_trap_clear_only: assert property (!core_control_reg[3] && !taken |=> !core_control_reg[3])
    else $error("trap bit set by software");
  a_field_frozen: assert property (nesting_disable && !taken |=> $stable(core_status_reg[7:5]))
    else $error("level field changed while frozen");
  a_reset_addr_zero: assert property (reset_addr == 24'h0)
    else $error("reset address not zero");
  c_trap: cover property (taken && irq_level[3]);
  c_user: cover property (taken && !irq_level[3]);
  c_alt: cover property (irq_request && irq_control_two[15]);
endmodule
bind prioritized_interrupt_vectoring irq_vec_sva u_irq_vec_sva (.core_clk(core_clk), .reset_n(reset_n),
  .irq_request(irq_request), .irq_ack(irq_ack), .nesting_disable(nesting_disable), .prio_rd_data(prio_rd_data),
  .core_status_reg(core_status_reg), .core_control_reg(core_control_reg), .irq_control_two(irq_control_two),
  .irq_vector(irq_vector), .irq_level(irq_level), .irq_vector_addr(irq_vector_addr), .reset_addr(reset_addr));

// [verification/core_ack_model.sv]
// core model that acknowledges an offer after a set wait
`timescale 1ns/1ps
module core_ack_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic irq_request,
  input wire logic [3:0] ack_wait,
  output logic irq_ack
);
  logic [3:0] wait_q;
  // ack stands for one edge only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
    end else if (irq_ack || !irq_request) begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
    end else if (wait_q >= ack_wait) begin
      irq_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// [verification/prioritized_interrupt_vectoring_test.sv]
// bench for the interrupt vectoring top
`timescale 1ns/1ps
module prioritized_interrupt_vectoring_test;
  logic core_clk = 0, reset_n = 0, prio_wr = 0, status_wr = 0, control_wr = 0, ctrl_two_wr = 0;
  logic nesting_disable = 0, alt = 0, irq_ack, irq_request;
  logic [7:0] src_pending = 8'h0;
  logic [3:0] trap_pending = 4'h0, ack_wait = 4'h0, irq_level;
  logic [15:0] wd = 16'h0, prio_rd_data, core_status_reg, core_control_reg, irq_control_two;
  logic [6:0] irq_vector;
  logic [4:0] pidx = 5'h0;
  logic [23:0] irq_vector_addr, reset_addr;
  int n_mismatch = 0, n_compared = 0;
  prioritized_interrupt_vectoring #(.NUM_SRC(8)) u_prioritized_interrupt_vectoring (.core_clk(core_clk),
    .reset_n(reset_n), .src_pending(src_pending), .trap_pending(trap_pending), .prio_wr(prio_wr),
    .prio_wr_index(pidx), .prio_wr_data(wd), .prio_rd_index(pidx), .prio_rd_data(prio_rd_data),
    .status_wr(status_wr), .status_wr_data(wd), .control_wr(control_wr), .control_wr_data(wd),
    .nesting_disable(nesting_disable), .core_status_reg(core_status_reg), .core_control_reg(core_control_reg),
    .ctrl_two_wr(ctrl_two_wr), .ctrl_two_wr_data(wd), .irq_control_two(irq_control_two),
    .irq_request(irq_request), .irq_vector(irq_vector), .irq_level(irq_level),
    .irq_vector_addr(irq_vector_addr), .irq_ack(irq_ack), .irq_return(1'b0), .reset_addr(reset_addr));
  core_ack_model u_core_ack_model (.core_clk(core_clk), .reset_n(reset_n), .irq_request(irq_request),
    .ack_wait(ack_wait), .irq_ack(irq_ack));
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  // one-cycle write strobe: 0 priority, 1 status, 2 control, 3 control two
  task automatic wr(input int k, input logic [15:0] d);
    wd = d;
    {prio_wr, status_wr, control_wr, ctrl_two_wr} = 4'(4'h8 >> k);
    tick();
    {prio_wr, status_wr, control_wr, ctrl_two_wr} = 4'h0;
    tick();
  endtask
  task automatic no_req();
    repeat (4) begin
      tick();
      check("idle", 24'(irq_request), 24'h0);
    end
  endtask
  // waits for an offer, compares it, then lets the ack edge pass
  task automatic take(input logic [6:0] v, input logic [3:0] l);
    int n;
    n = 0;
    while (irq_request !== 1'b1 && n < 20) begin tick(); n++; end
    check("vector", 24'(irq_vector), 24'(v));
    check("level", 24'(irq_level), 24'(l));
    check("addr", irq_vector_addr, (alt ? 24'h000104 : 24'h000004) + {16'h0, v, 1'b0});
    while (irq_ack !== 1'b1 && n < 40) begin tick(); n++; end
    tick();
    check("ack", 24'(n < 40), 24'h1);
  endtask
  initial forever #20 core_clk = ~core_clk;
  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1 reset_n = 1;
    tick();
    check("prio", 24'(prio_rd_data), 24'h4444);
    check("reset_addr", reset_addr, 24'h0);
    wr(0, 16'hFFFF);
    check("prio", 24'(prio_rd_data), 24'h7777);
    wr(0, 16'h0552);
    check("prio", 24'(prio_rd_data), 24'h0552);
    src_pending = 8'h0F;
    take(7'h09, 4'h5);
    src_pending = 8'h0D;
    no_req();
    ack_wait = 4'h3;
    wr(1, 16'h0);
    take(7'h0A, 4'h5);
    src_pending = 8'h09;
    wr(1, 16'h0);
    take(7'h08, 4'h2);
    src_pending = 8'h08;
    wr(1, 16'h0);
    no_req();
    wr(0, 16'h0752);
    wr(1, 16'h00E0);
    src_pending = 8'h06;
    no_req();
    trap_pending = 4'h8;
    take(7'h04, 4'hB);
    trap_pending = 4'h0;
    check("trap_bit", 24'(core_control_reg[3]), 24'h1);
    wr(2, 16'h0);
    check("trap_bit", 24'(core_control_reg[3]), 24'h0);
    wr(2, 16'h0008);
    check("trap_bit", 24'(core_control_reg[3]), 24'h0);
    wr(3, 16'h8000);
    alt = 1;
    check("alt", 24'(irq_control_two[15]), 24'h1);
    trap_pending = 4'hF;
    for (int i = 0; i < 4; i++) begin
      take(7'(i + 1), 4'(14 - i));
      trap_pending[i] = 1'b0;
      wr(2, 16'h0);
    end
    pidx = 5'h1;
    tick();
    check("prio", 24'(prio_rd_data), 24'h4444);
    wr(0, 16'h7007);
    check("prio", 24'(prio_rd_data), 24'h7007);
    src_pending = 8'h90;
    wr(1, 16'h0);
    take(7'h0C, 4'h7);
    check("field", 24'(core_status_reg[7:5]), 24'h7);
    nesting_disable = 1;
    wr(1, 16'h0060);
    check("field", 24'(core_status_reg[7:5]), 24'h7);
    complete_run();
  end
endmodule
